/* File: hw/switch_cfg_pkg.sv */
// How it works
// - code 01 loads bits 7:0 into sense type; 1 battery, 0 ground
// - closed programmable input reports 1 whatever its sense type
// - host may rewrite any register anytime in normal mode with interface supply present; device accepts
// - wake enable written by code 02 (prog 7:0) and 03 (ground 13:0)
// - wake bit 0 blocks interrupt and wake; 1 lets change raise both
// - contact current written by code 04 (prog) and 05 (ground)
// - contact current bit 0 selects 2.0 mA, 1 selects 16 mA
// - each input has 20 ms timer from threshold crossing, then drops to low current
// - timer enable written by code 07 (prog) and 08 (ground); 1 enables
// - disabled timer keeps high current on closed contact indefinitely
// - hi-z written by 09 and 0A; 1 forces hi-z, comparator still runs
// - analog code 06 bits 4:0 pick channel: 0 none, 1-14 ground, 15-22 prog
// - selected analog input reads 0 in next status stream
// - analog bits 6:5: 00 hi-z, 01 2.0 mA pull-up, 10 16 mA pull-up
// - analog bits 11 treated as hi-z analog input
// - analog command currents are always pull-up, never pull-down
// - every transfer is exactly 24 bits, status shifted out meanwhile
// - reset: battery sense, all wake, 16 mA, timers on, all hi-z, no channel
// - programming only in normal mode with interface supply present
package switch_cfg_pkg;
  localparam int          FRAME_BITS  = 24;
  localparam logic [7:0]  CMD_SENSE   = 8'h01;
  localparam logic [7:0]  CMD_WAKE_P  = 8'h02;
  localparam logic [7:0]  CMD_WAKE_G  = 8'h03;
  localparam logic [7:0]  CMD_CUR_P   = 8'h04;
  localparam logic [7:0]  CMD_CUR_G   = 8'h05;
  localparam logic [7:0]  CMD_ANALOG  = 8'h06;
  localparam logic [7:0]  CMD_TMR_P   = 8'h07;
  localparam logic [7:0]  CMD_TMR_G   = 8'h08;
  localparam logic [7:0]  CMD_HIZ_P   = 8'h09;
  localparam logic [7:0]  CMD_HIZ_G   = 8'h0A;
  localparam logic [7:0]  CMD_RESET   = 8'h7F;
  localparam int          CMD_MSB     = 23;
  localparam int          CMD_LSB     = 16;
  localparam int          PROG_N      = 8;
  localparam int          GND_N       = 14;
  localparam int          IN_N        = 22;
  localparam logic [4:0]  CH_NONE     = 5'h00;
  localparam logic [4:0]  CH_PROG0    = 5'h0F;
  localparam logic [4:0]  CH_LAST     = 5'h16;
  localparam logic [7:0]  SENSE_RST   = 8'hFF;
  localparam logic [21:0] ALL_ONES_RST = 22'h3FFFFF;
  localparam logic [6:0]  ANALOG_RST  = 7'h00;
  // open-contact comparator levels: ground inputs idle high, battery-sensed inputs idle low
  localparam logic [21:0] PIN_IDLE_RST = 22'h003FFF;
  localparam int          TIMER_MS    = 20;
  localparam int          CLK_MHZ     = 100;
  localparam int          TIMER_CYC   = TIMER_MS * 1000 * CLK_MHZ;
  localparam int          TMR_W       = 22;

  typedef enum logic [1:0] {
    SRC_HIZ  = 2'b00,
    SRC_LOW  = 2'b01,
    SRC_HIGH = 2'b10
  } source_t;

  typedef struct packed {
    logic [21:0] hiz;
    logic [21:0] high_cur;
    logic [21:0] pull_up;
  } drive_t;

  // channel code to one-hot input index, ground inputs in bits 13:0
  function automatic logic [21:0] chan_onehot(input logic [4:0] ch);
    logic [21:0] r;
    r = 22'h000000;
    if (ch != CH_NONE && ch <= CH_LAST) begin
      r[ch - 5'd1] = 1'b1;
    end
    return r;
  endfunction
endpackage

/* File: hw/switch_detect_spi_config.sv */
`timescale 1ns/1ps
module switch_detect_spi_config
  import switch_cfg_pkg::*;
#(
  parameter int TIMER_CYCLES = TIMER_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic        normal_mode,
  input  wire logic        iface_supply_ok,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  input  wire logic [7:0]  prog_input_bit,
  input  wire logic [13:0] gnd_input_bit,
  output logic [21:0]      switch_closed,
  output logic [7:0]       sense_battery,
  output logic [21:0]      wake_enable,
  output logic [21:0]      high_current,
  output logic [21:0]      input_hiz,
  output logic [21:0]      pull_up,
  output logic [4:0]       analog_channel,
  output logic [21:0]      analog_monitor_sel,
  output logic             attn_n
);
  // ==========================================================
  // input synchronisers
  logic [2:0]  s1_reg;
  logic [2:0]  s2_reg;
  logic [21:0] in1_reg;
  logic [21:0] in2_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg  <= 3'h7;
      s2_reg  <= 3'h7;
      // start from open contacts so the change detector sees no false edge after reset
      in1_reg <= PIN_IDLE_RST;
      in2_reg <= PIN_IDLE_RST;
    end else if (clk_en) begin
      s1_reg  <= {spi_sclk, spi_cs_n, spi_mosi};
      s2_reg  <= s1_reg;
      in1_reg <= {prog_input_bit, gnd_input_bit};
      in2_reg <= in1_reg;
    end
  end
  logic sclk_s;
  logic cs_s;
  logic mosi_s;
  assign sclk_s = s2_reg[2];
  assign cs_s   = s2_reg[1];
  assign mosi_s = s2_reg[0];

  // ==========================================================
  // closed-contact view: comparator high level per input type
  logic [21:0] closed_now;
  always_comb begin
    for (int i = 0; i < GND_N; i++) begin
      closed_now[i] = ~in2_reg[i];
    end
    for (int i = 0; i < PROG_N; i++) begin
      // battery sense closes high, ground sense closes low; closed is 1 either way
      closed_now[GND_N + i] = sense_battery[i] ? in2_reg[GND_N + i] : ~in2_reg[GND_N + i];
    end
  end

  // ==========================================================
  // serial frame engine
  logic        sclk_d_reg;
  logic        cs_d_reg;
  logic [23:0] rx_reg;
  logic [23:0] rx_next;
  logic [23:0] tx_reg;
  logic [23:0] tx_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic        frame_done;
  logic        cs_fall;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [21:0] status_mask;
  assign cs_fall   = cs_d_reg & ~cs_s;
  assign sclk_rise = ~sclk_d_reg & sclk_s & ~cs_s;
  assign sclk_fall = sclk_d_reg & ~sclk_s & ~cs_s;
  assign frame_done = ~cs_d_reg & cs_s & (cnt_reg == 5'(FRAME_BITS));

  always_comb begin
    rx_next  = rx_reg;
    tx_next  = tx_reg;
    cnt_next = cnt_reg;
    status_mask = ~chan_onehot(analog_channel);
    if (cs_fall) begin
      // selected analog channel reads 0 in the stream latched here
      tx_next  = {2'b00, closed_now[21:14], closed_now[13:0]} & {2'b11, status_mask};
      cnt_next = 5'd0;
    end else if (sclk_rise) begin
      rx_next = {rx_reg[22:0], mosi_s};
      if (cnt_reg != 5'd31) begin
        cnt_next = cnt_reg + 5'd1;
      end
    end else if (sclk_fall) begin
      tx_next = {tx_reg[22:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
      rx_reg     <= 24'h000000;
      tx_reg     <= 24'h000000;
      cnt_reg    <= 5'h00;
      spi_miso   <= 1'b0;
    end else if (clk_en) begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_s;
      rx_reg     <= rx_next;
      tx_reg     <= tx_next;
      cnt_reg    <= cnt_next;
      spi_miso   <= tx_next[23];
    end
  end

  // ==========================================================
  // configuration registers
  logic [7:0]  sense_reg;
  logic [7:0]  sense_next;
  logic [21:0] wake_reg;
  logic [21:0] wake_next;
  logic [21:0] cur_reg;
  logic [21:0] cur_next;
  logic [21:0] tmr_en_reg;
  logic [21:0] tmr_en_next;
  logic [21:0] hiz_reg;
  logic [21:0] hiz_next;
  logic [6:0]  ana_reg;
  logic [6:0]  ana_next;
  logic        accept;
  logic [7:0]  cmd;
  assign cmd    = rx_reg[CMD_MSB:CMD_LSB];
  assign accept = frame_done & normal_mode & iface_supply_ok;

  always_comb begin
    sense_next  = sense_reg;
    wake_next   = wake_reg;
    cur_next    = cur_reg;
    tmr_en_next = tmr_en_reg;
    hiz_next    = hiz_reg;
    ana_next    = ana_reg;
    if (accept) begin
      // only the field bits are taken; unused bits never reach a register
      unique case (cmd)
        CMD_SENSE:  sense_next = rx_reg[7:0];
        CMD_WAKE_P: wake_next[21:14] = rx_reg[7:0];
        CMD_WAKE_G: wake_next[13:0] = rx_reg[13:0];
        CMD_CUR_P:  cur_next[21:14] = rx_reg[7:0];
        CMD_CUR_G:  cur_next[13:0] = rx_reg[13:0];
        CMD_TMR_P:  tmr_en_next[21:14] = rx_reg[7:0];
        CMD_TMR_G:  tmr_en_next[13:0] = rx_reg[13:0];
        CMD_HIZ_P:  hiz_next[21:14] = rx_reg[7:0];
        CMD_HIZ_G:  hiz_next[13:0] = rx_reg[13:0];
        CMD_ANALOG: ana_next = rx_reg[6:0];
        CMD_RESET: begin
          sense_next  = SENSE_RST;
          wake_next   = ALL_ONES_RST;
          cur_next    = ALL_ONES_RST;
          tmr_en_next = ALL_ONES_RST;
          hiz_next    = ALL_ONES_RST;
          ana_next    = ANALOG_RST;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sense_reg  <= SENSE_RST;
      wake_reg   <= ALL_ONES_RST;
      cur_reg    <= ALL_ONES_RST;
      tmr_en_reg <= ALL_ONES_RST;
      hiz_reg    <= ALL_ONES_RST;
      ana_reg    <= ANALOG_RST;
    end else if (clk_en) begin
      sense_reg  <= sense_next;
      wake_reg   <= wake_next;
      cur_reg    <= cur_next;
      tmr_en_reg <= tmr_en_next;
      hiz_reg    <= hiz_next;
      ana_reg    <= ana_next;
    end
  end
  assign sense_battery  = sense_reg;
  assign wake_enable    = wake_reg;
  assign analog_channel = ana_reg[4:0];
  assign switch_closed  = closed_now;

  // ==========================================================
  // wetting timers, one per input
  logic [21:0] expired_reg;
  logic [21:0] change;
  logic [21:0] closed_d_reg;
  assign change = closed_now ^ closed_d_reg;
  genvar g;
  generate
    for (g = 0; g < IN_N; g++) begin : g_tmr
      logic [TMR_W-1:0] t_reg;
      logic [TMR_W-1:0] t_next;
      logic             e_next;
      always_comb begin
        t_next = t_reg;
        e_next = expired_reg[g];
        if (change[g]) begin
          // threshold crossing restarts the timer at high current
          t_next = '0;
          e_next = 1'b0;
        end else if (tmr_en_reg[g] && !expired_reg[g] && closed_now[g]) begin
          if (t_reg == TMR_W'(TIMER_CYCLES - 1)) begin
            e_next = 1'b1;
          end else begin
            t_next = t_reg + TMR_W'(1);
          end
        end else if (!tmr_en_reg[g]) begin
          e_next = 1'b0;
        end
      end
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          t_reg          <= '0;
          expired_reg[g] <= 1'b0;
        end else if (clk_en) begin
          t_reg          <= t_next;
          expired_reg[g] <= e_next;
        end
      end
    end
  endgenerate

  // ==========================================================
  // pin drive and attention
  logic [21:0] ana_sel;
  logic [21:0] idle_pull;
  // ground inputs always pull up; battery-sensed programmable inputs pull down
  assign idle_pull = {~sense_reg, {GND_N{1'b1}}};
  logic        attn_n_reg;
  assign ana_sel = chan_onehot(ana_reg[4:0]);
  drive_t drv;
  always_comb begin
    for (int i = 0; i < IN_N; i++) begin
      if (ana_sel[i]) begin
        // 11 is illegal and falls back to hi-z; analog sources only pull up
        drv.hiz[i]      = !(ana_reg[6:5] == SRC_LOW || ana_reg[6:5] == SRC_HIGH);
        drv.high_cur[i] = (ana_reg[6:5] == SRC_HIGH);
        drv.pull_up[i]  = 1'b1;
      end else begin
        drv.hiz[i]      = hiz_reg[i];
        drv.high_cur[i] = cur_reg[i] & ~expired_reg[i];
        drv.pull_up[i]  = idle_pull[i];
      end
    end
  end
  assign input_hiz          = drv.hiz;
  assign high_current       = drv.high_cur;
  assign pull_up            = drv.pull_up;
  assign analog_monitor_sel = ana_sel;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      closed_d_reg <= 22'h000000;
      attn_n_reg   <= 1'b1;
    end else if (clk_en) begin
      closed_d_reg <= closed_now;
      if (|(change & wake_reg)) begin
        attn_n_reg <= 1'b0;
      end else if (!cs_d_reg && cs_s) begin
        attn_n_reg <= 1'b1;
      end
    end
  end
  assign attn_n = attn_n_reg;

  // ==========================================================
  // checks
  chk_unknown_code_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && frame_done && cmd == 8'h00) |=> $stable(wake_reg) && $stable(cur_reg) && $stable(ana_reg))
    else $error("unknown command changed a register");
  chk_sense_load: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && accept && cmd == CMD_SENSE) |=> sense_reg == $past(rx_reg[7:0]))
    else $error("sense register not loaded");
  chk_wake_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    (clk_en && attn_n_reg && !(|(change & wake_reg))) |=> attn_n_reg)
    else $error("attention raised without enabled change");
  chk_mode_gate: assert property (@(posedge core_clk) disable iff (!resetn)
    (!normal_mode || !iface_supply_ok) |=> $stable(tmr_en_reg) && $stable(hiz_reg) && $stable(sense_reg) && $stable(wake_reg))
    else $error("register written outside normal mode");
  chk_short_frame: assert property (@(posedge core_clk) disable iff (!resetn)
    (cs_s && !cs_d_reg && cnt_reg != 5'(FRAME_BITS)) |=> $stable(sense_reg) && $stable(wake_reg))
    else $error("short frame updated a register");
  chk_analog_pullup: assert property (@(posedge core_clk) disable iff (!resetn)
    (ana_sel != 22'h000000) |-> ((ana_sel & pull_up) == ana_sel))
    else $error("analog channel not pulled up");
  chk_illegal_src: assert property (@(posedge core_clk) disable iff (!resetn)
    (ana_reg[6:5] == 2'b11) |-> ((ana_sel & input_hiz) == ana_sel))
    else $error("illegal source not hi-z");
  chk_timer_off: assert property (@(posedge core_clk) disable iff (!resetn)
    (tmr_en_reg == 22'h000000) |=> (expired_reg == 22'h000000))
    else $error("disabled timer dropped current");
endmodule

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// host side of the serial port
module spi_host_model (
  input  wire logic core_clk,
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // half bit of 80 ns; sclk stands low outside frames
  task automatic half();
    repeat (8) @(negedge core_clk);
  endtask

  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    rx = 24'h000000;
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      spi_mosi = tx[i];
      half();
      spi_sclk = 1'b1;
      rx[i] = spi_miso;
      half();
      spi_sclk = 1'b0;
    end
    half();
    spi_cs_n = 1'b1;
    // released data line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    // covers the accept latency and the gap between frames
    repeat (12) @(negedge core_clk);
  endtask
endmodule

/* File: testbench/switch_detect_spi_config_tb.sv */
`timescale 1ns/1ps
module switch_detect_spi_config_tb;
  import switch_cfg_pkg::*;
  localparam int TCYC = 50;
  logic        core_clk, resetn, clk_en, normal_mode, iface_supply_ok;
  logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, attn_n;
  logic [7:0]  prog_input_bit, sense_battery;
  logic [13:0] gnd_input_bit;
  logic [21:0] switch_closed, wake_enable, high_current, input_hiz, pull_up, analog_monitor_sel, oh;
  logic [4:0]  analog_channel;
  logic [23:0] rx;
  logic [4:0]  chs [4] = '{5'h01, 5'h0E, 5'h0F, 5'h16};
  logic [1:0]  srcs [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;

  switch_detect_spi_config #(.TIMER_CYCLES(TCYC)) u_switch_detect_spi_config (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .normal_mode(normal_mode),
    .iface_supply_ok(iface_supply_ok), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .prog_input_bit(prog_input_bit), .gnd_input_bit(gnd_input_bit),
    .switch_closed(switch_closed), .sense_battery(sense_battery), .wake_enable(wake_enable),
    .high_current(high_current), .input_hiz(input_hiz), .pull_up(pull_up),
    .analog_channel(analog_channel), .analog_monitor_sel(analog_monitor_sel), .attn_n(attn_n));

  spi_host_model u_spi_host_model (
    .core_clk(core_clk), .spi_miso(spi_miso), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================
  // access and compare tasks
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    u_spi_host_model.xfer({cmd, data}, 24, rx);
  endtask

  task automatic defaults();
    check("sense", sense_battery, SENSE_RST);
    check("wake", wake_enable, ALL_ONES_RST);
    check("hiz", input_hiz, ALL_ONES_RST);
    check("chan", analog_channel, CH_NONE);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    normal_mode = 1'b1;
    iface_supply_ok = 1'b1;
    prog_input_bit = 8'h00;
    gnd_input_bit = 14'h0000;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    defaults();
    wr(CMD_SENSE, 16'hFFA5);
    check("sense", sense_battery, 8'hA5);
    check("closed", switch_closed, 22'h16BFFF);
    wr(CMD_WAKE_P, 16'hFF3C);
    wr(CMD_WAKE_G, 16'hD234);
    check("wake", wake_enable, 22'h0F1234);
    // refused frames: unknown code, short frame, outside normal mode, no supply
    wr(8'h33, 16'h0000);
    u_spi_host_model.xfer({CMD_SENSE, 16'h0000}, 23, rx);
    normal_mode = 1'b0;
    wr(CMD_SENSE, 16'h0000);
    normal_mode = 1'b1;
    iface_supply_ok = 1'b0;
    wr(CMD_WAKE_P, 16'h0000);
    iface_supply_ok = 1'b1;
    // with the clock enable low the frame is never seen
    clk_en = 1'b0;
    wr(CMD_SENSE, 16'h0000);
    clk_en = 1'b1;
    check("sense", sense_battery, 8'hA5);
    check("wake", wake_enable, 22'h0F1234);
    wr(CMD_TMR_P, 16'h0000);
    wr(CMD_TMR_G, 16'h0000);
    wr(CMD_CUR_P, 16'h000F);
    wr(CMD_CUR_G, 16'h2001);
    wr(CMD_HIZ_P, 16'h0000);
    wr(CMD_HIZ_G, 16'h0000);
    repeat (2 * TCYC) @(negedge core_clk);
    check("high", high_current, 22'h03E001);
    check("hiz", input_hiz, 22'h000000);
    wr(CMD_TMR_G, 16'h2001);
    repeat (2 * TCYC) @(negedge core_clk);
    check("high", high_current, 22'h03C000);
    wr(CMD_SENSE, 16'h0000);
    check("sense", sense_battery, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(CMD_ANALOG, {9'h1FF, srcs[k], chs[k]});
      oh = 22'h000001 << (chs[k] - 5'd1);
      check("chan", analog_channel, chs[k]);
      check("msel", analog_monitor_sel, oh);
      check("pull", pull_up & oh, oh);
      check("hiz", input_hiz & oh, (srcs[k][0] ~^ srcs[k][1]) ? oh : 22'h0);
      if (srcs[k][0] ^ srcs[k][1]) begin
        check("high", high_current & oh, srcs[k][1] ? oh : 22'h0);
      end
      u_spi_host_model.xfer(24'h000000, 24, rx);
      check("status", rx, {2'b00, ~oh});
    end
    // a status frame releases attention raised by earlier activity
    wr(8'h00, 16'h0000);
    check("attn", attn_n, 1'b1);
    gnd_input_bit[0] = 1'b1;
    repeat (8) @(negedge core_clk);
    check("attn", attn_n, 1'b1);
    gnd_input_bit[2] = 1'b1;
    repeat (8) @(negedge core_clk);
    check("attn", attn_n, 1'b0);
    wr(8'h00, 16'h0000);
    check("attn", attn_n, 1'b1);
    wr(CMD_RESET, 16'h0000);
    defaults();
    summarize();
  end
endmodule
